// ===== design/pdc_dma.sv
// peripheral dma channels: sequencer, channel state and staging fifo
// assumes requests come from pins, programming and data from same clock
//
// Contract
// - each byte moved takes four system clock states
// - the cpu instruction slot lasts ten system clocks
// - an armed request halts the cpu and the engine takes the bus
// - after taking the bus the engine acknowledges the serviced channel
// - each channel moves memory to port or port to memory
// - after the programmed count the bus returns to the cpu
// - while the engine holds the bus the cpu gets a slot every 10 us
// - an exhausted count drives terminal count to the owning peripheral
// - the display channel reloads base and count and stays armed
// - each peripheral has one dedicated data port, others for command
// - the transmitter gets a byte at least every 250 clocks; disc and display blocks win arbitration and tx waits until they end
// - disc, display and transmitter each have a request/ack pair

// staging fifo between the read and write halves of a transfer
module pdc_fifo #(
	parameter int W = 27,
	parameter int D = 4
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int PW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);
	localparam logic [CW-1:0] FULL   = CW'(D);
	localparam logic [PW-1:0] LASTP  = PW'(D - 1);
	localparam logic [PW-1:0] P_ZERO = '0;
	localparam logic [PW-1:0] P_ONE  = PW'(1);
	localparam logic [CW-1:0] C_ONE  = CW'(1);

	logic [W-1:0]  mem_ff [D];
	logic [PW-1:0] wr_ptr_ff;
	logic [PW-1:0] rd_ptr_ff;
	logic [CW-1:0] cnt_ff;
	logic          push;
	logic          pop;

	// honest full and empty from the occupancy count
	assign in_ready  = (cnt_ff != FULL);
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem_ff[rd_ptr_ff];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	// pointers wrap at the depth
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_ff <= P_ZERO;
			rd_ptr_ff <= P_ZERO;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == LASTP) ? P_ZERO : wr_ptr_ff + P_ONE;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == LASTP) ? P_ZERO : rd_ptr_ff + P_ONE;
			end
		end
	end

	// occupancy
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (push && !pop) begin
			cnt_ff <= cnt_ff + C_ONE;
		end else if (pop && !push) begin
			cnt_ff <= cnt_ff - C_ONE;
		end
	end
endmodule : pdc_fifo

// dma engine top
module pdc_dma (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// peripheral handshake pins, one bit per channel
	input  wire logic [2:0]       dreq_pin,
	output logic [2:0]            channel_grant_ack_ff,
	output logic [2:0]            tc_ff,
	// channel programming from the cpu core
	input  wire logic             prog_we,
	input  wire logic [1:0]       prog_chan,
	input  wire pdc_pkg::pdc_prog_t prog_cfg,
	output logic [2:0]            armed_ff,
	// system bus ownership, cpu halted while high
	output logic                  bus_master_ff,
	// read half of a transfer
	output logic [15:0]           rd_addr_ff,
	output logic                  mem_rd_ff,
	output logic [2:0]            io_rd_sel_ff,
	input  wire logic [7:0]       mem_rdata,
	input  wire logic [7:0]       io_rdata,
	// write half of a transfer
	input  wire logic             dst_ready,
	output logic [15:0]           wr_addr_ff,
	output logic                  mem_wr_ff,
	output logic [2:0]            io_wr_sel_ff,
	output logic [7:0]            wdata_ff
);
	localparam int WW = $bits(pdc_pkg::pdc_word_t);

	pdc_pkg::pdc_state_t st_ff;
	pdc_pkg::pdc_state_t nxt_st;
	logic [2:0]          req_meta_ff;
	logic [2:0]          req_sync_ff;
	logic [1:0]          act_ff;
	logic [15:0]         base_ff [pdc_pkg::NCH];
	logic [15:0]         len_ff  [pdc_pkg::NCH];
	logic [15:0]         cur_ff  [pdc_pkg::NCH];
	logic [15:0]         cnt_ff  [pdc_pkg::NCH];
	logic [2:0]          to_mem_ff;
	logic [2:0]          auto_ff;
	logic [7:0]          slot_cnt_ff;
	logic [3:0]          cpu_cnt_ff;
	logic [2:0]          want;
	logic                last_byte;
	logic                rd_hold;
	logic                fifo_in_ready;
	logic                fifo_out_valid;
	logic                fifo_out_ready;
	logic                pop;
	pdc_pkg::pdc_word_t  push_word;
	pdc_pkg::pdc_word_t  pop_word;

	// one-hot select of a channel
	function automatic logic [2:0] chan_hot(input logic [1:0] ch);
		chan_hot = 3'h1 << ch;
	endfunction : chan_hot

	// fixed priority pick, lowest channel number first
	function automatic logic [1:0] prio_pick(input logic [2:0] w);
		if (w[0]) begin
			prio_pick = pdc_pkg::CH_DISC;
		end else if (w[1]) begin
			prio_pick = pdc_pkg::CH_CRT;
		end else begin
			prio_pick = pdc_pkg::CH_TX;
		end
	endfunction : prio_pick

	// request pins cross into the clock domain through two flops
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			req_meta_ff <= 3'h0;
			req_sync_ff <= 3'h0;
		end else begin
			req_meta_ff <= dreq_pin;
			req_sync_ff <= req_meta_ff;
		end
	end

	// a request counts only for a programmed channel
	assign want      = req_sync_ff & armed_ff;
	assign last_byte = (cnt_ff[act_ff] == pdc_pkg::CNT_LAST);
	assign rd_hold   = (st_ff == pdc_pkg::S_T1) ||
	                   ((st_ff == pdc_pkg::S_T2) && !fifo_in_ready);

	// sequencer next state
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			pdc_pkg::S_IDLE: begin
				if (|want) begin
					nxt_st = pdc_pkg::S_GRANT;
				end
			end
			pdc_pkg::S_GRANT: nxt_st = pdc_pkg::S_T1;
			pdc_pkg::S_T1: nxt_st = pdc_pkg::S_T2;
			pdc_pkg::S_T2: begin
				if (fifo_in_ready) begin
					nxt_st = pdc_pkg::S_T3;
				end
			end
			pdc_pkg::S_T3: nxt_st = pdc_pkg::S_T4;
			pdc_pkg::S_T4: begin
				if (last_byte) begin
					nxt_st = pdc_pkg::S_DRAIN;
				end else if (slot_cnt_ff >= pdc_pkg::SLOT_DUE) begin
					nxt_st = pdc_pkg::S_YIELD;
				end else if (want[act_ff]) begin
					nxt_st = pdc_pkg::S_T1;
				end else begin
					nxt_st = pdc_pkg::S_DRAIN;
				end
			end
			pdc_pkg::S_DRAIN: begin
				if (!fifo_out_valid) begin
					nxt_st = pdc_pkg::S_IDLE;
				end
			end
			pdc_pkg::S_YIELD: begin
				if (!fifo_out_valid) begin
					nxt_st = pdc_pkg::S_CPU;
				end
			end
			pdc_pkg::S_CPU: begin
				if (cpu_cnt_ff == pdc_pkg::CPU_LAST) begin
					nxt_st = pdc_pkg::S_IDLE;
				end
			end
			default: nxt_st = pdc_pkg::S_IDLE;
		endcase
	end

	// state register and serviced channel, one channel at a time
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff  <= pdc_pkg::S_IDLE;
			act_ff <= pdc_pkg::CH_DISC;
		end else begin
			st_ff <= nxt_st;
			if (st_ff == pdc_pkg::S_IDLE && (|want)) begin
				act_ff <= prio_pick(want);
			end
		end
	end

	// bus ownership and acknowledge follow the next state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bus_master_ff        <= 1'b0;
			channel_grant_ack_ff <= 3'h0;
		end else begin
			bus_master_ff <= (nxt_st != pdc_pkg::S_IDLE) &&
			                 (nxt_st != pdc_pkg::S_CPU);
			case (nxt_st)
				pdc_pkg::S_T1, pdc_pkg::S_T2, pdc_pkg::S_T3, pdc_pkg::S_T4:
					channel_grant_ack_ff <= chan_hot(act_ff);
				default: channel_grant_ack_ff <= 3'h0;
			endcase
		end
	end

	// channel registers: programming, stepping and autoload
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			armed_ff  <= 3'h0;
			to_mem_ff <= 3'h0;
			auto_ff   <= 3'h0;
			for (int i = 0; i < pdc_pkg::NCH; i++) begin
				base_ff[i] <= pdc_pkg::ZERO16;
				len_ff[i]  <= pdc_pkg::ZERO16;
				cur_ff[i]  <= pdc_pkg::ZERO16;
				cnt_ff[i]  <= pdc_pkg::ZERO16;
			end
		end else begin
			for (int i = 0; i < pdc_pkg::NCH; i++) begin
				if (prog_we && prog_chan == 2'(i) &&
				    !(bus_master_ff && act_ff == 2'(i))) begin
					base_ff[i]   <= prog_cfg.base;
					len_ff[i]    <= prog_cfg.count;
					cur_ff[i]    <= prog_cfg.base;
					cnt_ff[i]    <= prog_cfg.count;
					to_mem_ff[i] <= prog_cfg.to_mem;
					auto_ff[i]   <= prog_cfg.autoload &&
					                (2'(i) == pdc_pkg::CH_CRT);
					armed_ff[i]  <= (prog_cfg.count != pdc_pkg::ZERO16);
				end
			end
			if (st_ff == pdc_pkg::S_T4) begin
				if (last_byte && auto_ff[act_ff]) begin
					cur_ff[act_ff] <= base_ff[act_ff];
					cnt_ff[act_ff] <= len_ff[act_ff];
				end else begin
					cur_ff[act_ff] <= cur_ff[act_ff] + pdc_pkg::ADDR_INC;
					cnt_ff[act_ff] <= cnt_ff[act_ff] - pdc_pkg::CNT_LAST;
					if (last_byte) begin
						armed_ff[act_ff] <= 1'b0;
					end
				end
			end
		end
	end

	// terminal count pulse to the owning peripheral
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tc_ff <= 3'h0;
		end else if (st_ff == pdc_pkg::S_T4 && last_byte) begin
			tc_ff <= chan_hot(act_ff);
		end else begin
			tc_ff <= 3'h0;
		end
	end

	// read half: address in t1, strobe through t2 and any stall
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_addr_ff   <= pdc_pkg::ZERO16;
			mem_rd_ff    <= 1'b0;
			io_rd_sel_ff <= 3'h0;
		end else begin
			if (st_ff == pdc_pkg::S_T1) begin
				rd_addr_ff <= cur_ff[act_ff];
			end
			mem_rd_ff    <= rd_hold && !to_mem_ff[act_ff];
			io_rd_sel_ff <= (rd_hold && to_mem_ff[act_ff]) ?
			                chan_hot(act_ff) : 3'h0;
		end
	end

	// staged byte carries its own destination
	always_comb begin
		push_word        = '0;
		push_word.to_mem = to_mem_ff[act_ff];
		push_word.chan   = act_ff;
		push_word.addr   = rd_addr_ff;
		push_word.data   = to_mem_ff[act_ff] ? io_rdata : mem_rdata;
	end

	// writes only while the engine owns the bus
	assign fifo_out_ready = dst_ready && bus_master_ff;
	assign pop            = fifo_out_valid && fifo_out_ready;

	pdc_fifo #(
		.W (WW),
		.D (pdc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (st_ff == pdc_pkg::S_T2),
		.in_ready  (fifo_in_ready),
		.in_data   (push_word),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (pop_word)
	);

	// write half: one strobe cycle per popped byte
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_addr_ff   <= pdc_pkg::ZERO16;
			wdata_ff     <= 8'h00;
			mem_wr_ff    <= 1'b0;
			io_wr_sel_ff <= 3'h0;
		end else begin
			if (pop) begin
				wr_addr_ff <= pop_word.addr;
				wdata_ff   <= pop_word.data;
			end
			mem_wr_ff    <= pop && pop_word.to_mem;
			io_wr_sel_ff <= (pop && !pop_word.to_mem) ?
			                chan_hot(pop_word.chan) : 3'h0;
		end
	end

	// mastership time since the last cpu slot
	always_ff @(posedge clk) begin
		if (!rst_n || !bus_master_ff) begin
			slot_cnt_ff <= 8'h00;
		end else if (slot_cnt_ff != pdc_pkg::SLOT_MAX) begin
			slot_cnt_ff <= slot_cnt_ff + 8'h01;
		end
	end

	// length of the cpu instruction slot
	always_ff @(posedge clk) begin
		if (!rst_n || st_ff != pdc_pkg::S_CPU) begin
			cpu_cnt_ff <= 4'h0;
		end else begin
			cpu_cnt_ff <= cpu_cnt_ff + 4'h1;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	byte_four_states_a: assert property (
		(st_ff == pdc_pkg::S_T1 && fifo_in_ready) |-> ##3
		(st_ff == pdc_pkg::S_T4)) else $error("byte not four states");
	cpu_slot_len_a: assert property (
		(st_ff == pdc_pkg::S_CPU && nxt_st != pdc_pkg::S_CPU) |->
		(cpu_cnt_ff == pdc_pkg::CPU_LAST)) else $error("cpu slot length");
	bus_take_a: assert property (
		(st_ff == pdc_pkg::S_IDLE && (|want)) |=> bus_master_ff)
		else $error("bus not taken");
	grant_ack_a: assert property (
		(st_ff == pdc_pkg::S_T2) |->
		(channel_grant_ack_ff == chan_hot(act_ff) && bus_master_ff))
		else $error("ack wrong channel");
	read_dir_a: assert property (
		(st_ff == pdc_pkg::S_T2) |-> (to_mem_ff[act_ff] ?
		(io_rd_sel_ff == chan_hot(act_ff) && !mem_rd_ff) :
		(mem_rd_ff && io_rd_sel_ff == 3'h0))) else $error("read direction");
	bus_release_a: assert property (
		(st_ff == pdc_pkg::S_DRAIN && !fifo_out_valid) |=> !bus_master_ff)
		else $error("bus not released");
	slot_bound_a: assert property (
		(st_ff != pdc_pkg::S_YIELD && st_ff != pdc_pkg::S_DRAIN) |->
		(slot_cnt_ff <= pdc_pkg::SLOT_DUE + 8'(pdc_pkg::XFER_STATES)))
		else $error("cpu slot overdue");
	term_count_a: assert property (
		(st_ff == pdc_pkg::S_T4 && last_byte) |=>
		(tc_ff == chan_hot($past(act_ff)))) else $error("no terminal count");
	autoload_a: assert property (
		(st_ff == pdc_pkg::S_T4 && last_byte && auto_ff[act_ff]) |=>
		(armed_ff[pdc_pkg::CH_CRT] &&
		cnt_ff[pdc_pkg::CH_CRT] == len_ff[pdc_pkg::CH_CRT]))
		else $error("autoload missed");
	tx_pace_a: assert property (
		(st_ff == pdc_pkg::S_T4 && act_ff == pdc_pkg::CH_TX &&
		nxt_st == pdc_pkg::S_T1) |-> ##[1:30] (st_ff == pdc_pkg::S_T4))
		else $error("transmitter starved");
	fixed_prio_a: assert property (
		(st_ff == pdc_pkg::S_IDLE && want[0]) |=>
		(act_ff == pdc_pkg::CH_DISC)) else $error("priority order");

	crt_reload_c: cover property (st_ff == pdc_pkg::S_T4 && last_byte &&
		auto_ff[act_ff]);
	cpu_slot_c: cover property (st_ff == pdc_pkg::S_CPU);
	fifo_full_c: cover property (!fifo_in_ready);
	tx_done_c: cover property (tc_ff[pdc_pkg::CH_TX]);
endmodule : pdc_dma

// ===== design/pdc_pkg.sv
// shared constants and types of the peripheral dma channels
// assumes one 10 mhz system clock and a synchronous active-low reset
package pdc_pkg;

	// channel numbering, lowest number has the highest priority
	localparam int         NCH     = 3;
	localparam logic [1:0] CH_DISC = 2'h0;
	localparam logic [1:0] CH_CRT  = 2'h1;
	localparam logic [1:0] CH_TX   = 2'h2;

	// timing
	localparam int         CLK_NS        = 100;
	localparam int         XFER_STATES   = 4;
	localparam int         CPU_INSN_CLKS = 10;
	localparam int         CPU_SLOT_NS   = 10000;
	localparam int         SLOT_CLKS     = CPU_SLOT_NS / CLK_NS;
	localparam int         TX_BYTE_CLKS  = 250;
	localparam logic [7:0] SLOT_DUE      = 8'(SLOT_CLKS - CPU_INSN_CLKS);
	localparam logic [7:0] SLOT_MAX      = 8'hff;
	localparam logic [3:0] CPU_LAST      = 4'(CPU_INSN_CLKS - 1);

	// reset and step values
	localparam logic [15:0] CNT_LAST = 16'h0001;
	localparam logic [15:0] ADDR_INC = 16'h0001;
	localparam logic [15:0] ZERO16   = 16'h0000;

	// staging buffer
	localparam int FIFO_DEPTH = 4;

	// sequencer states
	typedef enum logic [3:0] {
		S_IDLE, S_GRANT, S_T1, S_T2, S_T3, S_T4, S_DRAIN, S_YIELD, S_CPU
	} pdc_state_t;

	// channel programming word
	typedef struct packed {
		logic [15:0] base;
		logic [15:0] count;
		logic        to_mem;
		logic        autoload;
	} pdc_prog_t;

	// one staged byte with its destination
	typedef struct packed {
		logic        to_mem;
		logic [1:0]  chan;
		logic [15:0] addr;
		logic [7:0]  data;
	} pdc_word_t;

endpackage : pdc_pkg

// ===== dv/pdc_dma_test.sv
// self-checking bench of the dma engine with its peripheral model
// assumes a 10 mhz clock and no other master on the bus
module pdc_dma_test;
	timeunit 1ns;
	timeprecision 1ns;

	// design inputs
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	logic               prog_we = 1'b0;
	logic [1:0]         prog_chan = 2'h0;
	pdc_pkg::pdc_prog_t prog_cfg = '0;
	logic [2:0]         req_on = 3'h0;
	logic               hold_off = 1'b0;
	// outputs
	logic [2:0]  dreq_pin, ack, tc_ff, armed_ff, io_rd_sel_ff, io_wr_sel_ff, irq;
	logic        bus_master_ff, mem_rd_ff, mem_wr_ff, dst_ready;
	logic [15:0] rd_addr_ff, wr_addr_ff, ebase;
	logic [7:0]  mem_rdata, io_rdata, wdata_ff;
	// bookkeeping
	int          fail_count, comparisons, cyc, wcnt, ackc, mx, maxmx;
	int          gap, mingap, lasttx, maxtx;
	logic        chk = 1'b0;
	logic        eto;
	logic [1:0]  ech;

	always #50 clk = ~clk;

	pdc_dma dut (.clk(clk), .rst_n(rst_n), .dreq_pin(dreq_pin),
		.channel_grant_ack_ff(ack), .tc_ff(tc_ff), .prog_we(prog_we),
		.prog_chan(prog_chan), .prog_cfg(prog_cfg), .armed_ff(armed_ff),
		.bus_master_ff(bus_master_ff), .rd_addr_ff(rd_addr_ff),
		.mem_rd_ff(mem_rd_ff), .io_rd_sel_ff(io_rd_sel_ff),
		.mem_rdata(mem_rdata), .io_rdata(io_rdata), .dst_ready(dst_ready),
		.wr_addr_ff(wr_addr_ff), .mem_wr_ff(mem_wr_ff),
		.io_wr_sel_ff(io_wr_sel_ff), .wdata_ff(wdata_ff));

	pdc_periph_model peer (.clk(clk), .rst_n(rst_n), .req_on(req_on),
		.hold_off(hold_off), .tc_ff(tc_ff), .mem_rd_ff(mem_rd_ff),
		.io_rd_sel_ff(io_rd_sel_ff), .rd_addr_ff(rd_addr_ff),
		.dreq_pin(dreq_pin), .mem_rdata(mem_rdata), .io_rdata(io_rdata),
		.dst_ready(dst_ready), .irq_ff(irq));

	// compare one value and count it
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	// watchdog, bus occupancy, ack cycles and every write while chk is set
	always @(posedge clk) begin
		cyc++;
		if (|ack) ackc++;
		if (bus_master_ff) begin
			mx++;
			if (gap > 0 && gap < mingap) mingap = gap;
			gap = 0;
		end else begin
			if (mx > maxmx) maxmx = mx;
			mx = 0;
			gap++;
		end
		if (chk && io_wr_sel_ff[2]) begin
			if (lasttx > 0 && cyc - lasttx > maxtx) maxtx = cyc - lasttx;
			lasttx = cyc;
		end
		if (chk && (mem_wr_ff || |io_wr_sel_ff)) begin
			if (eto) begin
				check("target", 32'({mem_wr_ff, io_wr_sel_ff}),
				      32'h8);
				check("wr_addr", 32'(wr_addr_ff),
				      32'(ebase + 16'(wcnt)));
				check("wdata", 32'(wdata_ff),
				      32'(8'hc0 + 8'(ech)));
			end else begin
				check("target", 32'({mem_wr_ff, io_wr_sel_ff}),
				      32'(4'h1 << ech));
				check("wdata", 32'(wdata_ff),
				      32'(8'(ebase + 16'(wcnt)) ^ 8'h3c));
			end
			wcnt++;
		end
		// a simulation that outlives 5000 cycles in total counts as a mismatch
		if (cyc > 5000) begin
			fail_count++;
			complete_run();
		end
	end

	task automatic prog(logic [1:0] ch, logic [15:0] b, logic [15:0] n,
		logic tm, logic al);
		@(posedge clk);
		prog_we <= 1'b1;
		prog_chan <= ch;
		prog_cfg <= '{base: b, count: n, to_mem: tm, autoload: al};
		@(posedge clk);
		prog_we <= 1'b0;
	endtask : prog

	task automatic wait_bus(logic lvl);
		// look only at settled values, never in the edge's own time step
		@(negedge clk);
		for (int i = 0; i < 50 && bus_master_ff !== lvl; i++) @(negedge clk);
		check("bus_master", 32'(bus_master_ff), 32'(lvl));
	endtask : wait_bus

	// program, request, follow one block to its terminal count
	task automatic run(logic [1:0] ch, logic [15:0] b, logic [15:0] n,
		logic tm, logic al, logic st, logic [2:0] also);
		prog(ch, b, n, tm, al);
		@(negedge clk);
		check("armed", 32'(armed_ff[ch]), 32'h1);
		ech = ch;
		ebase = b;
		eto = tm;
		chk = 1'b1;
		wcnt = 0;
		ackc = 0;
		maxmx = 0;
		mingap = 999;
		gap = -100000;
		lasttx = 0;
		maxtx = 0;
		@(posedge clk);
		req_on <= req_on | also | (3'h1 << ch);
		hold_off <= st;
		wait_bus(1'b1);
		@(negedge clk);
		check("ack", 32'(ack), 32'(3'h1 << ch));
		if (st) begin
			repeat (30) @(posedge clk);
			hold_off <= 1'b0;
		end
		for (int i = 0; i < 3000 && tc_ff[ch] !== 1'b1; i++) @(negedge clk);
		check("tc", 32'(tc_ff), 32'(3'h1 << ch));
		chk = 1'b0;
		if (!st) check("ack cycles", ackc, 32'(4 * n));
		check("writes", wcnt, 32'(n));
		// the peripheral turns terminal count into its interrupt
		@(negedge clk);
		check("irq", 32'(irq), 32'(3'h1 << ch));
		@(posedge clk);
		req_on[ch] <= 1'b0;
		wait_bus(1'b0);
		check("armed after", 32'(armed_ff[ch]), 32'(al));
		repeat (12) @(posedge clk);
	endtask : run

	// zero count does not arm, an unarmed request is ignored
	task automatic s_unarmed();
		prog(2'h2, 16'h1000, 16'h0, 1'b0, 1'b0);
		@(negedge clk);
		check("armed zero", 32'(armed_ff), 32'h0);
		@(posedge clk);
		req_on <= 3'h4;
		repeat (20) @(negedge clk);
		check("bus idle", 32'(bus_master_ff), 32'h0);
		@(posedge clk);
		req_on <= 3'h0;
	endtask : s_unarmed

	// disc and transmitter request together, disc wins, then tx follows
	task automatic s_prio();
		prog(2'h2, 16'h5000, 16'h2, 1'b0, 1'b0);
		run(2'h0, 16'h0100, 16'h2, 1'b0, 1'b0, 1'b0, 3'h4);
		for (int i = 0; i < 200 && armed_ff[2] !== 1'b0; i++) @(negedge clk);
		// only the autoloaded display channel is still armed here
		check("tx served", 32'(armed_ff), 32'h2);
		@(posedge clk);
		req_on <= 3'h0;
		repeat (12) @(posedge clk);
	endtask : s_prio

	// long transmitter block: cpu slots and byte spacing
	task automatic s_long();
		run(2'h2, 16'h2000, 16'd60, 1'b0, 1'b0, 1'b0, 3'h0);
		check("max master",
		      32'(maxmx <= pdc_pkg::SLOT_CLKS), 32'h1);
		check("cpu slot",
		      32'(mingap >= pdc_pkg::CPU_INSN_CLKS && mingap < 999), 32'h1);
		check("tx spacing",
		      32'(maxtx <= pdc_pkg::TX_BYTE_CLKS), 32'h1);
	endtask : s_long

	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check("reset",
		      32'({bus_master_ff, ack, tc_ff, armed_ff}), 32'h0);
		s_unarmed();
		// single byte, then a run whose address wraps its low byte
		run(2'h0, 16'h1200, 16'h1, 1'b0, 1'b0, 1'b0, 3'h0);
		run(2'h1, 16'h34fe, 16'h5, 1'b0, 1'b0, 1'b0, 3'h0);
		// port to memory with the destination stalled so the buffer fills
		run(2'h2, 16'h8000, 16'h8, 1'b1, 1'b0, 1'b1, 3'h0);
		// display channel reloads itself
		run(2'h1, 16'h0400, 16'h3, 1'b0, 1'b1, 1'b0, 3'h0);
		s_prio();
		s_long();
		complete_run();
	end
endmodule : pdc_dma_test

// ===== dv/pdc_periph_model.sv
// peripheral side model: request pins, data ports and memory data
// assumes the engine strobes and terminal count are registered outputs
module pdc_periph_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// bench controls
	input  wire logic [2:0]  req_on,
	input  wire logic        hold_off,
	// engine side
	input  wire logic [2:0]  tc_ff,
	input  wire logic        mem_rd_ff,
	input  wire logic [2:0]  io_rd_sel_ff,
	input  wire logic [15:0] rd_addr_ff,
	output logic [2:0]       dreq_pin,
	output logic [7:0]       mem_rdata,
	output logic [7:0]       io_rdata,
	output logic             dst_ready,
	output logic [2:0]       irq_ff
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [2:0] done_ff;
	logic [7:0] junk_ff;

	// a peripheral holds its request until its terminal count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done_ff <= 3'h0;
		end else begin
			done_ff <= (done_ff | tc_ff) & req_on;
		end
	end
	assign dreq_pin = req_on & ~done_ff & ~tc_ff;

	// terminal count turns into an interrupt toward the cpu
	always_ff @(posedge clk) begin
		irq_ff <= rst_n ? tc_ff : 3'h0;
	end

	// data lines not driven change every cycle, so stale bytes never match
	always_ff @(posedge clk) begin
		junk_ff <= rst_n ? junk_ff + 8'h5b : 8'h00;
	end
	assign mem_rdata = mem_rd_ff ? (rd_addr_ff[7:0] ^ 8'h3c) : junk_ff;

	// each channel answers only on its own dedicated data port
	always_comb begin
		case (io_rd_sel_ff)
			3'h1:    io_rdata = 8'hc0;
			3'h2:    io_rdata = 8'hc1;
			3'h4:    io_rdata = 8'hc2;
			default: io_rdata = junk_ff;
		endcase
	end
	assign dst_ready = ~hold_off;
endmodule : pdc_periph_model
